// ==== hdl/gpc_pkg.sv ====
// constants for the port pad configuration subregisters
package gpc_pkg;
	localparam int GPC_W = 8;
	localparam logic [7:0] GPC_IDX_STRONG = 8'h04;
	localparam logic [7:0] GPC_IDX_WAKE = 8'h05;
	localparam logic [7:0] GPC_IDX_PULLUP = 8'h06;
	localparam logic [7:0] GPC_IDX_AFS1 = 8'h07;
	localparam logic [7:0] GPC_IDX_AFS2 = 8'h08;
	localparam logic [7:0] GPC_RST_ZERO = 8'h00;
	localparam logic [7:0] GPC_RST_AFS_SMALL = 8'h04;
endpackage

// ==== hdl/gpc_subreg.sv ====
// one 8-bit subregister with selectable reset value
`timescale 1ns/10ps
module gpc_subreg
	import gpc_pkg::*;
#(
	parameter logic [7:0] RST_VAL = GPC_RST_ZERO
) (
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic wr_en_in,
	input wire logic [7:0] wr_data_in,
	output logic [7:0] q_out
);
	logic [7:0] q_ff;
	logic [7:0] nxt_q;
	assign nxt_q = wr_en_in ? wr_data_in : q_ff;
	assign q_out = q_ff;
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			q_ff <= RST_VAL;
		end else begin
			q_ff <= nxt_q;
		end
	end
endmodule

// ==== hdl/gpc_pad_config.sv ====
// pad configuration subregisters, wake request and pad control outputs
// Behaviour
// - port window accesses reach the subregister chosen by the current address index.
// - index 04h selects the strong-drive enable subregister.
// - strong-drive bit 1 gives high output current, 0 gives standard current.
// - strong drive acts on the pad directly, also under alternate function.
// - index 05h selects the wake source enable subregister.
// - in stop mode any edge on a wake-enabled pin starts stop-mode recovery.
// - in stop mode edges on pins with wake bit 0 start no recovery.
// - index 06h selects the weak pull-up enable subregister.
// - pull-up bit 1 enables the weak pull-up, 0 disables it.
// - index 07h selects the first alternate-function select subregister.
// - index 08h selects the second alternate-function select subregister.
// - the two select bits choose a peripheral only while alternate function is enabled.
// - alternate function takes precedence over the data direction setting.
// - both select subregisters reset to 00h, or 04h on port A of the smallest package.
// - every subregister is 8 bits, read/write, bit n for pin n.
`timescale 1ns/10ps
module gpc_pad_config
	import gpc_pkg::*;
#(
	parameter bit SMALL_PORT_A = 1'b0
) (
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic [7:0] port_addr_in,
	input wire logic port_window_wr_in,
	input wire logic [7:0] port_window_wdata_in,
	output logic [7:0] port_window_rdata_out,
	input wire logic stop_mode_in,
	input wire logic [7:0] pin_level_in,
	input wire logic [7:0] altfunc_enable_reg_in,
	input wire logic [7:0] pin_direction_reg_in,
	output logic wake_request_out,
	output logic [7:0] strong_drive_bit_out,
	output logic [7:0] weak_pullup_bit_out,
	output logic [7:0] af_sel_first_out,
	output logic [7:0] af_sel_second_out,
	output logic [7:0] af_active_out,
	output logic [7:0] pin_input_mode_out
);
	localparam logic [7:0] AFS_RST = SMALL_PORT_A ? GPC_RST_AFS_SMALL : GPC_RST_ZERO;
	logic [7:0] strong_q, wake_q, pullup_q, afs1_q, afs2_q;
	logic [7:0] pin_prev_ff;
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;
	logic [7:0] nxt_pin_prev;
	logic [7:0] pin_edge;
	// index decode
	wire sel_strong = port_addr_in == GPC_IDX_STRONG;
	wire sel_wake = port_addr_in == GPC_IDX_WAKE;
	wire sel_pullup = port_addr_in == GPC_IDX_PULLUP;
	wire sel_afs1 = port_addr_in == GPC_IDX_AFS1;
	wire sel_afs2 = port_addr_in == GPC_IDX_AFS2;
	wire wr_strong = port_window_wr_in & sel_strong;
	wire wr_wake = port_window_wr_in & sel_wake;
	wire wr_pullup = port_window_wr_in & sel_pullup;
	wire wr_afs1 = port_window_wr_in & sel_afs1;
	wire wr_afs2 = port_window_wr_in & sel_afs2;
	gpc_subreg #(.RST_VAL(GPC_RST_ZERO)) u_strong (
		.mclk_in(mclk_in),
		.sys_rst_in(sys_rst_in),
		.wr_en_in(wr_strong),
		.wr_data_in(port_window_wdata_in),
		.q_out(strong_q)
	);
	gpc_subreg #(.RST_VAL(GPC_RST_ZERO)) u_wake (
		.mclk_in(mclk_in),
		.sys_rst_in(sys_rst_in),
		.wr_en_in(wr_wake),
		.wr_data_in(port_window_wdata_in),
		.q_out(wake_q)
	);
	gpc_subreg #(.RST_VAL(GPC_RST_ZERO)) u_pullup (
		.mclk_in(mclk_in),
		.sys_rst_in(sys_rst_in),
		.wr_en_in(wr_pullup),
		.wr_data_in(port_window_wdata_in),
		.q_out(pullup_q)
	);
	gpc_subreg #(.RST_VAL(AFS_RST)) u_afs1 (
		.mclk_in(mclk_in),
		.sys_rst_in(sys_rst_in),
		.wr_en_in(wr_afs1),
		.wr_data_in(port_window_wdata_in),
		.q_out(afs1_q)
	);
	gpc_subreg #(.RST_VAL(AFS_RST)) u_afs2 (
		.mclk_in(mclk_in),
		.sys_rst_in(sys_rst_in),
		.wr_en_in(wr_afs2),
		.wr_data_in(port_window_wdata_in),
		.q_out(afs2_q)
	);
	assign nxt_rdata = sel_strong ? strong_q :
		sel_wake ? wake_q :
		sel_pullup ? pullup_q :
		sel_afs1 ? afs1_q :
		sel_afs2 ? afs2_q : GPC_RST_ZERO;
	assign strong_drive_bit_out = strong_q;
	assign weak_pullup_bit_out = pullup_q;
	assign af_sel_first_out = afs1_q & altfunc_enable_reg_in;
	assign af_sel_second_out = afs2_q & altfunc_enable_reg_in;
	assign af_active_out = altfunc_enable_reg_in;
	assign pin_input_mode_out = pin_direction_reg_in & ~altfunc_enable_reg_in;
	assign pin_edge = (pin_level_in ^ pin_prev_ff) & wake_q;
	assign nxt_pin_prev = pin_level_in;
	assign wake_request_out = stop_mode_in & (|pin_edge);
	assign port_window_rdata_out = rdata_ff;
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pin_prev_ff <= GPC_RST_ZERO;
			rdata_ff <= GPC_RST_ZERO;
		end else begin
			pin_prev_ff <= nxt_pin_prev;
			rdata_ff <= nxt_rdata;
		end
	end
	AST_WAKE_ON_EDGE: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(stop_mode_in && |((pin_level_in ^ $past(pin_level_in)) & wake_q)) |-> wake_request_out)
		else $error("wake missed");
	AST_NO_WAKE: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		wake_request_out |-> stop_mode_in && |((pin_level_in ^ $past(pin_level_in)) & wake_q))
		else $error("spurious wake");
	AST_WAKE_STOP: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		!stop_mode_in |-> !wake_request_out)
		else $error("wake outside stop mode");
	AST_STRONG_WR: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		wr_strong |=> strong_drive_bit_out == $past(port_window_wdata_in))
		else $error("strong drive write lost");
	AST_WAKE_WR: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		wr_wake |=> wake_q == $past(port_window_wdata_in))
		else $error("wake write lost");
	AST_PULLUP_WR: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		wr_pullup |=> weak_pullup_bit_out == $past(port_window_wdata_in))
		else $error("pullup write lost");
	AST_AFS1_WR: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		wr_afs1 |=> afs1_q == $past(port_window_wdata_in))
		else $error("select one write lost");
	AST_AFS2_WR: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		wr_afs2 |=> afs2_q == $past(port_window_wdata_in))
		else $error("select two write lost");
	AST_STRONG_HOLD: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		!wr_strong |=> $stable(strong_q))
		else $error("strong drive changed without write");
	AST_WAKE_HOLD: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		!wr_wake |=> $stable(wake_q))
		else $error("wake source changed without write");
	AST_PULLUP_HOLD: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		!wr_pullup |=> $stable(pullup_q))
		else $error("pullup changed without write");
	AST_AFS1_HOLD: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		!wr_afs1 |=> $stable(afs1_q))
		else $error("select one changed without write");
	AST_AFS2_HOLD: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		!wr_afs2 |=> $stable(afs2_q))
		else $error("select two changed without write");
	AST_RD_STRONG: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		sel_strong |=> port_window_rdata_out == $past(strong_q))
		else $error("read of strong drive wrong");
	AST_RD_WAKE: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		sel_wake |=> port_window_rdata_out == $past(wake_q))
		else $error("read of wake source wrong");
	AST_READ_MUX: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		sel_pullup |=> port_window_rdata_out == $past(pullup_q))
		else $error("read mux wrong");
	AST_RD_AFS1: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		sel_afs1 |=> port_window_rdata_out == $past(afs1_q))
		else $error("read of select one wrong");
	AST_RD_AFS2: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		sel_afs2 |=> port_window_rdata_out == $past(afs2_q))
		else $error("read of select two wrong");
	AST_RD_UNMAPPED: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		!(sel_strong || sel_wake || sel_pullup || sel_afs1 || sel_afs2) |=> port_window_rdata_out == GPC_RST_ZERO)
		else $error("unmapped read not zero");
	AST_AF_GATE: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		af_sel_first_out == (afs1_q & altfunc_enable_reg_in) &&
		af_sel_second_out == (afs2_q & altfunc_enable_reg_in))
		else $error("select leaks");
	AST_AF_DIR: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		pin_input_mode_out == (pin_direction_reg_in & ~altfunc_enable_reg_in))
		else $error("direction not overridden");
	AST_RST_CLEAR: assert property (@(posedge mclk_in)
		sys_rst_in ##1 sys_rst_in |->
		strong_q == GPC_RST_ZERO && wake_q == GPC_RST_ZERO && pullup_q == GPC_RST_ZERO)
		else $error("drive, wake or pullup not cleared");
	AST_RST_AFS: assert property (@(posedge mclk_in)
		sys_rst_in ##1 sys_rst_in |-> afs1_q == AFS_RST && afs2_q == AFS_RST)
		else $error("select reset value wrong");
	COV_WAKE: cover property (@(posedge mclk_in) disable iff (sys_rst_in) wake_request_out);
	COV_STRONG: cover property (@(posedge mclk_in) disable iff (sys_rst_in) wr_strong);
	COV_AFS2: cover property (@(posedge mclk_in) disable iff (sys_rst_in) wr_afs2);
	COV_EDGE_NO_STOP: cover property (@(posedge mclk_in) disable iff (sys_rst_in) !stop_mode_in && |pin_edge);
	COV_AF_SEL: cover property (@(posedge mclk_in) disable iff (sys_rst_in) |af_sel_first_out);
endmodule

// ==== tb/gpc_pins.sv ====
// partner model of the external port pins
`timescale 1ns/10ps
module gpc_pins (
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic [7:0] tog_in,
	output logic [7:0] pin_level_out
);
	// pins idle low, flip when asked
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			pin_level_out <= 8'h00;
		else
			pin_level_out <= pin_level_out ^ tog_in;
	end
endmodule

// ==== tb/testbench.sv ====
// self-checking bench for the pad configuration subregisters
`timescale 1ns/10ps
module testbench;
	import gpc_pkg::*;
	logic clk = 0, rst = 1, wr = 0, stop = 0, rd_req = 0, wake;
	logic [7:0] addr = 0, wd = 0, af = 0, dir = 0, tog = 0, rdata, rdata_s, pins, sd, pu, a1, a2, aa, im;
	logic [7:0] q[$];
	logic [7:0] q_small[$];
	logic [7:0] shadow[10] = '{default: 8'h00};
	int fail_count = 0, total_checks = 0, seed = 86, i;
	gpc_pins pins_m (.mclk_in(clk), .sys_rst_in(rst), .tog_in(tog), .pin_level_out(pins));
	gpc_pad_config #(.SMALL_PORT_A(1'b0)) dut (.mclk_in(clk), .sys_rst_in(rst), .port_addr_in(addr),
		.port_window_wr_in(wr), .port_window_wdata_in(wd), .port_window_rdata_out(rdata), .stop_mode_in(stop),
		.pin_level_in(pins), .altfunc_enable_reg_in(af), .pin_direction_reg_in(dir), .wake_request_out(wake),
		.strong_drive_bit_out(sd), .weak_pullup_bit_out(pu), .af_sel_first_out(a1), .af_sel_second_out(a2),
		.af_active_out(aa), .pin_input_mode_out(im));
	gpc_pad_config #(.SMALL_PORT_A(1'b1)) dut_small (.mclk_in(clk), .sys_rst_in(rst), .port_addr_in(addr),
		.port_window_wr_in(wr), .port_window_wdata_in(wd), .port_window_rdata_out(rdata_s), .stop_mode_in(stop),
		.pin_level_in(pins), .altfunc_enable_reg_in(af), .pin_direction_reg_in(dir), .wake_request_out(),
		.strong_drive_bit_out(), .weak_pullup_bit_out(), .af_sel_first_out(), .af_sel_second_out(),
		.af_active_out(), .pin_input_mode_out());
	initial forever #4 clk = ~clk;
	task chk_rd(input string n, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask
	task chk_pad(input string n, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask
	task chk_wake(input string n, input logic e, input logic g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s exp %b got %b", n, e, g);
		end
	endtask
	function automatic logic [7:0] rst_small(input logic [7:0] a);
		return (a == GPC_IDX_AFS1 || a == GPC_IDX_AFS2) ? GPC_RST_AFS_SMALL : GPC_RST_ZERO;
	endfunction
	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) #1 addr = a;
		wd = d;
		wr = 1;
		@(posedge clk) #1 wr = 0;
		if (a <= 8'h08)
			shadow[a] = d;
	endtask
	task rd_reg(input logic [7:0] a, input logic [7:0] e, input logic [7:0] es);
		@(posedge clk) #1 addr = a;
		rd_req = 1;
		q.push_back(e);
		q_small.push_back(es);
		@(posedge clk) #1 rd_req = 0;
	endtask
	task rd_reset_all;
		for (int k = 4; k <= 9; k++) rd_reg(k[7:0], GPC_RST_ZERO, rst_small(k[7:0]));
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// read data watcher
	always @(posedge clk) begin
		if (rd_req) begin
			#2 chk_rd("rdata", q.pop_front(), rdata);
			chk_rd("rdata_small", q_small.pop_front(), rdata_s);
		end
	end
	initial begin
		#100000 fail_count++;
		finish_test();
	end
	initial begin
		repeat (10) @(posedge clk);
		#1 rst = 0;
		rd_reset_all();
		for (i = 4; i <= 9; i++) wr_reg(i[7:0], 8'($random(seed)));
		for (i = 4; i <= 9; i++) rd_reg(i[7:0], shadow[i], shadow[i]);
		for (i = 0; i < 4; i++) begin
			@(posedge clk) #1 af = 8'($random(seed));
			dir = 8'($random(seed));
			stop = 1;
			@(posedge clk) #1 chk_pad("strong", shadow[4], sd);
			chk_pad("pullup", shadow[6], pu);
			chk_pad("afsel1", shadow[7] & af, a1);
			chk_pad("afsel2", shadow[8] & af, a2);
			chk_pad("afact", af, aa);
			chk_pad("inmode", dir & ~af, im);
		end
		for (i = 0; i < 16; i++) begin
			@(posedge clk) #1 tog = 8'($random(seed));
			stop = 1'($random(seed));
			@(posedge clk) #1 chk_wake("wake", stop & (|(tog & shadow[5])), wake);
			tog = 0;
		end
		@(posedge clk) #1 rst = 1;
		repeat (2) @(posedge clk);
		#1 rst = 0;
		shadow = '{default: 8'h00};
		chk_pad("strong_rst", GPC_RST_ZERO, sd);
		chk_pad("pullup_rst", GPC_RST_ZERO, pu);
		rd_reset_all();
		for (i = 0; i < 10 && (q.size() > 0 || q_small.size() > 0); i++) @(posedge clk);
		if (q.size() > 0 || q_small.size() > 0)
			fail_count++;
		finish_test();
	end
endmodule
